// *** hdl/fbp_pwm.v ***
// Four-channel bridge modulator with gate gaps and trigger pulses.
// Assumes a single clock, a same-domain register port, and drivers
// that need no more than the programmed gaps between bridge halves.
//
// Contract
// R1 - Four channels, separate high and low outputs
// R2 - One shared counter keeps channels synchronous
// R3 - Cycle length is limit plus one clocks
// R4 - All timing values count in clock periods
// R5 - One alignment setting for all channels
// R6 - Chopper codes 000-100 fixed output states
// R7 - Codes 101/110 modulate one side only
// R8 - Code 111 complementary with gaps inserted
// R9 - Shared low-side turn-on gap
// R10 - Shared high-side turn-on gap
// R11 - Separate high and low polarity inversion
// R12 - Trigger output polarity programmable
// R13 - Cycle start and center trigger pulses
// R14 - Two independently positioned trigger pulses
// R15 - Combined output ORs both positioned pulses
// R16 - Programmable width for all four pulses
// R17 - Per-channel duty value sets on-time
// R18 - Per-channel shift moves edges, keeps duty
// R19 - Software keeps gaps short but safe
// R20 - Left on below duty, right mirrored
// R21 - Centered on-time symmetric about midpoint
// R22 - Pulses last exactly programmed length
`timescale 1ns/1ps
`include "fbp_map.vh"

module fbp_pwm (
  // Clock, reset, enable
  input  wire        clock,
  input  wire        rstn,
  input  wire        ce,
  // Register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // Gate outputs
  output reg  [3:0]  high_side_output,
  output reg  [3:0]  low_side_output,
  // Trigger outputs
  output reg         start_trigger,
  output reg         center_trigger,
  output reg         trigger_a,
  output reg         trigger_b,
  output reg         either_positioned_trigger
);

  // ****************************************
  // Configuration registers
  // ****************************************
  reg  [11:0] period_count_limit;
  reg  [1:0]  align;
  reg         inv_high;
  reg         inv_low;
  reg         inv_trig;
  reg  [7:0]  low_turn_on_gap;
  reg  [7:0]  high_turn_on_gap;
  reg  [11:0] chopper_selector;
  reg  [11:0] pos_a;
  reg  [11:0] pos_b;
  reg  [7:0]  pulse_len;
  reg  [11:0] duty_mem  [0:3];
  reg  [11:0] shift_mem [0:3];
  reg  [11:0] cnt;
  integer     k;
  integer     m;
  wire [3:0]  next_high_all;
  wire [3:0]  next_low_all;

  wire [12:0] period = {1'b0, period_count_limit} + 13'h0001; // R3
  wire [12:0] mid    = {1'b0, period[12:1]};

  always @(posedge clock) begin
    if (!rstn) begin
      period_count_limit <= `FBP_RST_LIMIT;
      align              <= `FBP_ALIGN_LEFT;
      inv_high           <= 1'b0;
      inv_low            <= 1'b0;
      inv_trig           <= 1'b0;
      low_turn_on_gap    <= 8'h00;
      high_turn_on_gap   <= 8'h00;
      chopper_selector   <= 12'h000;
      pos_a              <= 12'h000;
      pos_b              <= 12'h000;
      pulse_len          <= `FBP_RST_TRIG_LEN;
      for (k = 0; k < 4; k = k + 1) begin
        duty_mem[k]  <= 12'h000;
        shift_mem[k] <= 12'h000;
      end
    end else if (ce && wr) begin
      case (addr)
        `FBP_REG_CFG: begin
          period_count_limit <= wdata[`FBP_CFG_LIMIT_MSB:0]; // R3
          align              <= wdata[`FBP_CFG_ALIGN_LSB+1:`FBP_CFG_ALIGN_LSB]; // R5
          inv_high           <= wdata[`FBP_CFG_INV_HIGH]; // R11
          inv_low            <= wdata[`FBP_CFG_INV_LOW]; // R11
          inv_trig           <= wdata[`FBP_CFG_INV_TRIG]; // R12
        end
        `FBP_REG_GAP: begin
          low_turn_on_gap  <= wdata[7:0]; // R9
          high_turn_on_gap <= wdata[`FBP_GAP_HIGH_LSB+7:`FBP_GAP_HIGH_LSB]; // R10
        end
        `FBP_REG_CHOP: begin
          chopper_selector <= wdata[11:0];
        end
        `FBP_REG_TRIG_POS: begin
          pos_a <= wdata[11:0]; // R14
          pos_b <= wdata[`FBP_TRIG_B_LSB+11:`FBP_TRIG_B_LSB]; // R14
        end
        `FBP_REG_TRIG_LEN: begin
          pulse_len <= wdata[7:0]; // R16
        end
        default: begin
          for (k = 0; k < 4; k = k + 1) begin
            if (addr == `FBP_REG_DUTY0 + 8'h04 * k[7:0]) begin
              duty_mem[k] <= wdata[11:0]; // R17
            end
            if (addr == `FBP_REG_SHIFT0 + 8'h04 * k[7:0]) begin
              shift_mem[k] <= wdata[11:0]; // R18
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h00000000;
    case (addr)
      `FBP_REG_CFG:      next_rdata = {15'h0000, inv_trig, inv_low, inv_high,
                                       align, period_count_limit};
      `FBP_REG_GAP:      next_rdata = {16'h0000, high_turn_on_gap, low_turn_on_gap};
      `FBP_REG_CHOP:     next_rdata = {20'h00000, chopper_selector};
      `FBP_REG_TRIG_POS: next_rdata = {4'h0, pos_b, 4'h0, pos_a};
      `FBP_REG_TRIG_LEN: next_rdata = {24'h000000, pulse_len};
      `FBP_REG_STATUS:   next_rdata = {20'h00000, cnt};
      default: begin
        for (m = 0; m < 4; m = m + 1) begin
          if (addr == `FBP_REG_DUTY0 + 8'h04 * m[7:0]) begin
            next_rdata = {20'h00000, duty_mem[m]};
          end
          if (addr == `FBP_REG_SHIFT0 + 8'h04 * m[7:0]) begin
            next_rdata = {20'h00000, shift_mem[m]};
          end
        end
      end
    endcase
  end

  // Read data in the cycle after an enabled strobe, zero after other enabled cycles, held while ce is low
  always @(posedge clock) begin
    if (!rstn) begin
      rdata <= 32'h00000000;
    end else if (ce) begin
      rdata <= rd ? next_rdata : 32'h00000000;
    end
  end

  // ****************************************
  // Shared cycle counter
  // ****************************************
  // Lowering the limit below the count wraps at once, no long run-out
  always @(posedge clock) begin
    if (!rstn) begin
      cnt <= 12'h000;
    end else if (ce) begin
      if (cnt >= period_count_limit) begin
        cnt <= 12'h000; // R2
      end else begin
        cnt <= cnt + 12'h001; // R3
      end
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  // Shift is signed; keep it within half a cycle so one wrap fixes it
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
      wire [11:0] duty  = duty_mem[ch];
      wire [11:0] shift = shift_mem[ch];
      wire [2:0]  mode  = chopper_selector[3*ch+2:3*ch];
      wire        full  = {1'b0, duty} >= period;
      wire [12:0] slack = full ? 13'h0000 : period - {1'b0, duty};
      reg  [12:0] base;
      reg  [13:0] d0;
      reg  [13:0] d1;
      reg         want;
      reg         dem_q;
      reg  [7:0]  gcnt;
      reg  [7:0]  since;
      reg         next_high;
      reg         next_low;

      always @* begin
        case (align)
          `FBP_ALIGN_RIGHT:  base = slack; // R20
          `FBP_ALIGN_CENTER: base = {1'b0, slack[12:1]}; // R21
          default:           base = 13'h0000; // R20
        endcase
        d0 = {2'b00, cnt} - {1'b0, base} - {{2{shift[11]}}, shift}; // R18
        if (d0[13]) begin
          d1 = d0 + {1'b0, period};
        end else if (d0 >= {1'b0, period}) begin
          d1 = d0 - {1'b0, period};
        end else begin
          d1 = d0;
        end
        want = full | (d1 < {2'b00, duty}); // R17
      end

      // Gap counter restarts at every change of the high demand
      always @(posedge clock) begin
        if (!rstn) begin
          dem_q <= 1'b0;
          gcnt  <= 8'h00;
        end else if (ce) begin
          dem_q <= want;
          if (want != dem_q) begin
            gcnt <= 8'h01;
          end else if (gcnt != 8'hFF) begin
            gcnt <= gcnt + 8'h01; // R4
          end
        end
      end

      // Elapsed clocks since the demand changed, zero in the change cycle,
      // so a gap of g leaves exactly g clocks with both sides off
      always @* begin
        since     = (want != dem_q) ? 8'h00 : gcnt;
        next_high = 1'b0;
        next_low  = 1'b0;
        case (mode)
          `FBP_CHOP_LOW_ON:   next_low  = 1'b1; // R6
          `FBP_CHOP_HIGH_ON:  next_high = 1'b1; // R6
          `FBP_CHOP_LOW_MOD:  next_low  = want; // R7
          `FBP_CHOP_HIGH_MOD: next_high = want; // R7
          `FBP_CHOP_COMPL: begin
            // Each side waits its own gap after the other switched off
            next_high = want & (since >= high_turn_on_gap); // R8 R10
            next_low  = ~want & (since >= low_turn_on_gap); // R8 R9
          end
          default: begin
            next_high = 1'b0; // R6
            next_low  = 1'b0;
          end
        endcase
      end

      assign next_high_all[ch] = next_high;
      assign next_low_all[ch]  = next_low;
    end
  endgenerate

  // ****************************************
  // Gate outputs
  // ****************************************
  // One process owns each gate vector
  always @(posedge clock) begin
    if (!rstn) begin
      high_side_output <= 4'h0;
      low_side_output  <= 4'h0;
    end else if (ce) begin
      high_side_output <= next_high_all ^ {4{inv_high}}; // R1 R11
      low_side_output  <= next_low_all ^ {4{inv_low}}; // R1 R11
    end
  end

  // ****************************************
  // Trigger pulses
  // ****************************************
  wire [3:0] hit;
  wire [3:0] active;

  assign hit[0] = (cnt == 12'h000); // R13
  assign hit[1] = ({1'b0, cnt} == mid); // R13
  assign hit[2] = (cnt == pos_a); // R14
  assign hit[3] = (cnt == pos_b); // R14

  genvar tg;
  generate
    for (tg = 0; tg < 4; tg = tg + 1) begin : g_trig
      reg [7:0] left;

      // A new hit during a pulse restarts its length
      always @(posedge clock) begin
        if (!rstn) begin
          left <= 8'h00;
        end else if (ce) begin
          if (hit[tg]) begin
            left <= pulse_len; // R16 R22
          end else if (left != 8'h00) begin
            left <= left - 8'h01; // R22
          end
        end
      end

      assign active[tg] = (left != 8'h00);
    end
  endgenerate

  always @(posedge clock) begin
    if (!rstn) begin
      start_trigger             <= 1'b0;
      center_trigger            <= 1'b0;
      trigger_a                 <= 1'b0;
      trigger_b                 <= 1'b0;
      either_positioned_trigger <= 1'b0;
    end else if (ce) begin
      start_trigger             <= active[0] ^ inv_trig; // R12 R13
      center_trigger            <= active[1] ^ inv_trig; // R12 R13
      trigger_a                 <= active[2] ^ inv_trig; // R12
      trigger_b                 <= active[3] ^ inv_trig; // R12
      either_positioned_trigger <= (active[2] | active[3]) ^ inv_trig; // R15
    end
  end

endmodule // fbp_pwm

// *** hdl/fbp_map.vh ***
// Register offsets, field positions, reset values and timing counts
// of the four-channel bridge modulator. Definitions only.
`ifndef FBP_MAP_VH
`define FBP_MAP_VH

// ****************************************
// Clock and timing
// ****************************************
`define FBP_CLK_PERIOD_PS    25000
`define FBP_MAX_PERIOD_PS    40960000
`define FBP_MAX_PERIOD_CYC   ((`FBP_MAX_PERIOD_PS) / (`FBP_CLK_PERIOD_PS))

// ****************************************
// Register byte offsets
// ****************************************
`define FBP_REG_CFG          8'h00
`define FBP_REG_GAP          8'h04
`define FBP_REG_CHOP         8'h08
`define FBP_REG_TRIG_POS     8'h0C
`define FBP_REG_TRIG_LEN     8'h10
`define FBP_REG_DUTY0        8'h14
`define FBP_REG_SHIFT0       8'h24
`define FBP_REG_STATUS       8'h34

// ****************************************
// Field positions
// ****************************************
`define FBP_CFG_LIMIT_MSB    11
`define FBP_CFG_ALIGN_LSB    12
`define FBP_CFG_INV_HIGH     14
`define FBP_CFG_INV_LOW      15
`define FBP_CFG_INV_TRIG     16
`define FBP_GAP_HIGH_LSB     8
`define FBP_TRIG_B_LSB       16

// ****************************************
// Encodings and reset values
// ****************************************
`define FBP_ALIGN_LEFT       2'h0
`define FBP_ALIGN_CENTER     2'h1
`define FBP_ALIGN_RIGHT      2'h2
`define FBP_CHOP_LOW_ON      3'h1
`define FBP_CHOP_HIGH_ON     3'h2
`define FBP_CHOP_LOW_MOD     3'h5
`define FBP_CHOP_HIGH_MOD    3'h6
`define FBP_CHOP_COMPL       3'h7
`define FBP_RST_LIMIT        12'hFFF
`define FBP_RST_TRIG_LEN     8'h01

`endif

// *** tb/fbp_bridge_model.sv ***
// Gate-driver model for four half bridges.
// Assumes the bench gives it the wiring polarity and when to watch.
`timescale 1ns/1ps
module fbp_bridge_model (
  // Control
  input  wire       clock,
  input  wire       watch,
  input  wire       inv,
  // Gates
  input  wire [3:0] gate_high,
  input  wire [3:0] gate_low,
  // Faults
  output reg  [7:0] shoots
);
  wire [3:0] on_h = gate_high ^ {4{inv}};
  wire [3:0] on_l = gate_low ^ {4{inv}};
  initial shoots = 8'h00;
  // Both switches of one leg on shorts the supply
  always @(posedge clock) begin
    if (watch && (on_h & on_l) != 4'h0) begin
      shoots <= shoots + 8'h01;
    end
  end
endmodule // fbp_bridge_model

// *** tb/fbp_pwm_asserts.sv ***
// Checker for the bridge modulator, bound onto its top ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "fbp_map.vh"
module fbp_pwm_asserts (
  // Bus
  input wire        clock,
  input wire        rstn,
  input wire        ce,
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  // Outputs
  input wire [3:0]  high_side_output,
  input wire [3:0]  low_side_output,
  input wire        start_trigger,
  input wire        center_trigger,
  input wire        trigger_a,
  input wire        trigger_b,
  input wire        either_positioned_trigger
);
  reg  [16:0] cfg;
  reg  [2:0]  chop0;
  reg  [7:0]  len;
  reg  [3:0]  quiet;
  reg  [7:0]  run;
  wire        iv = cfg[`FBP_CFG_INV_TRIG];
  wire        st = start_trigger ^ iv;
  wire [3:0]  h  = high_side_output ^ {4{cfg[`FBP_CFG_INV_HIGH]}};
  wire [3:0]  l  = low_side_output ^ {4{cfg[`FBP_CFG_INV_LOW]}};
  // Outputs lag writes, so checks wait for a quiet bus
  always @(posedge clock) begin
    if (!rstn) begin
      cfg <= 17'h0;
      chop0 <= 3'h0;
      len <= `FBP_RST_TRIG_LEN;
      quiet <= 4'h0;
      run <= 8'h00;
    end else if (ce) begin
      if (wr && addr == `FBP_REG_CFG) cfg <= wdata[16:0];
      if (wr && addr == `FBP_REG_CHOP) chop0 <= wdata[2:0];
      if (wr && addr == `FBP_REG_TRIG_LEN) len <= wdata[7:0];
      quiet <= wr ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
      run <= st ? run + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_reset_outs: assert property ($rose(rstn) |-> rdata == 32'h0 &&
    high_side_output == 4'h0 && low_side_output == 4'h0) else $error("outputs not clear");
  chk_rdata_idle: assert property (ce && !rd |=> rdata == 32'h0)
    else $error("read data outside read cycle");
  chk_status_upper: assert property (ce && rd && addr == `FBP_REG_STATUS |=>
    rdata[31:12] == 20'h0) else $error("status above 12 bits");
  chk_unmapped_read: assert property (ce && rd && addr == 8'hFC |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_freeze_hold: assert property (!ce |=> $stable(high_side_output) &&
    $stable(start_trigger) && $stable(rdata)) else $error("moved while frozen");
  chk_no_cross: assert property (quiet > 4'h3 |-> (h & l) == 4'h0)
    else $error("both sides on");
  chk_fixed_chop: assert property (quiet == 4'hF && chop0 <= 3'h4 |-> {h[0], l[0]} ==
    (chop0 == 3'h1 ? 2'b01 : chop0 == 3'h2 ? 2'b10 : 2'b00)) else $error("fixed mode wrong");
  chk_either_or: assert property (quiet > 4'h3 |-> (either_positioned_trigger ^ iv) ==
    ((trigger_a ^ iv) | (trigger_b ^ iv))) else $error("combined trigger wrong");
  chk_pulse_len: assert property (quiet == 4'hF && $past(st) && !st |-> run == len)
    else $error("pulse length wrong");
  cov_start: cover property ($rose(st));
  cov_compl: cover property (chop0 == 3'h7 && h[0]);
  cov_freeze: cover property (!ce);
endmodule // fbp_pwm_asserts
bind fbp_pwm fbp_pwm_asserts i_fbp_pwm_asserts (.clock, .rstn, .ce, .addr, .wdata, .wr,
  .rd, .rdata, .high_side_output, .low_side_output, .start_trigger, .center_trigger,
  .trigger_a, .trigger_b, .either_positioned_trigger);

// *** tb/fbp_pwm_tb_top.sv ***
// Self-checking bench for the bridge modulator.
// Assumes the map header on the include path and a 40 MHz clock.
`timescale 1ns/1ps
`include "fbp_map.vh"
module fbp_pwm_tb_top;
  reg         clock = 1'b0;
  reg         rstn  = 1'b0;
  reg         ce    = 1'b1;
  reg  [7:0]  addr  = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         wr    = 1'b0;
  reg         rd    = 1'b0;
  reg         watch = 1'b0;
  wire [31:0] rdata;
  wire [3:0]  hs;
  wire [3:0]  ls;
  wire        st;
  wire        ct;
  wire        et;
  wire        pa;
  wire        pb;
  wire [7:0]  shoots;
  reg  [9:0]  p;
  reg  [9:0]  e;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  integer hc[4], lc[4], sc, cc, ec, ac, bc;
  int base, k, c;
  int hx[8] = '{0, 0, 10, 0, 0, 0, 4, 3};
  int lx[8] = '{0, 10, 0, 0, 0, 4, 0, 4};
  int al[4] = '{0, 1, 2, 1};
  int sh[4] = '{0, 0, 0, 2};
  fbp_pwm i_fbp_pwm (.clock(clock), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .high_side_output(hs), .low_side_output(ls),
    .start_trigger(st), .center_trigger(ct), .trigger_a(pa), .trigger_b(pb),
    .either_positioned_trigger(et));
  fbp_bridge_model i_fbp_bridge_model (.clock(clock), .watch(watch), .inv(1'b0),
    .gate_high(hs), .gate_low(ls), .shoots(shoots));
  always #12.5 clock = ~clock;
  task complete_run;
    begin
      $display("mismatches %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // A hang ends the run as a mismatch
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      complete_run;
    end
  end
  task chk(input string what, input [31:0] x, input [31:0] g);
    begin
      comparisons++;
      if (g !== x) begin
        n_errors++;
        $display("unexpected %s: expected %h seen %h", what, x, g);
      end
    end
  endtask
  task wreg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [7:0] a, input [31:0] x, input [31:0] m, input string what);
    begin
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk(what, x, rdata & m);
    end
  endtask
  task per(input int n);
    int i, j;
    begin
      sc = 0;
      cc = 0;
      ec = 0;
      ac = 0;
      bc = 0;
      hc = '{0, 0, 0, 0};
      lc = '{0, 0, 0, 0};
      for (i = 0; i < n; i++) begin
        @(posedge clock);
        #1;
        for (j = 0; j < 4; j++) begin
          hc[j] += hs[j];
          lc[j] += ls[j];
        end
        sc += st;
        cc += ct;
        ec += et;
        ac += pa;
        bc += pb;
      end
    end
  endtask
  // Sample channel 0 from a start pulse rising edge
  task grab(output reg [9:0] q);
    int i;
    begin
      i = 0;
      #1;
      while (st !== 1'b0 && i < 40) begin
        @(posedge clock);
        #1;
        i++;
      end
      while (st !== 1'b1 && i < 40) begin
        @(posedge clock);
        #1;
        i++;
      end
      for (i = 0; i < 10; i++) begin
        q[i] = hs[0];
        @(posedge clock);
        #1;
      end
    end
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    rreg(`FBP_REG_CFG, 32'h00000FFF, 32'hFFFFFFFF, "cfg");
    rreg(`FBP_REG_TRIG_LEN, 32'h1, 32'hFFFFFFFF, "length");
    rreg(8'hFC, 32'h0, 32'hFFFFFFFF, "unmapped");
    wreg(`FBP_REG_CFG, 32'h9);
    wreg(`FBP_REG_GAP, 32'h0102);
    wreg(`FBP_REG_TRIG_POS, 32'h00070002);
    wreg(`FBP_REG_TRIG_LEN, 32'h2);
    for (k = 0; k < 4; k++) wreg(`FBP_REG_DUTY0 + 8'(k * 4), 32'h4);
    watch <= 1'b1;
    for (c = 0; c < 8; c++) begin
      wreg(`FBP_REG_CHOP, {20'h0, {4{3'(c)}}});
      repeat (12) @(posedge clock);
      per(10);
      for (k = 0; k < 4; k++) begin
        chk("high on", hx[c], hc[k]);
        chk("low on", lx[c], lc[k]);
      end
    end
    per(40);
    chk("start", 32'd8, sc);
    chk("center", 32'd8, cc);
    chk("either", 32'd16, ec);
    chk("trigger a", 32'd8, ac);
    chk("trigger b", 32'd8, bc);
    wreg(`FBP_REG_DUTY0, 32'h3);
    wreg(`FBP_REG_CHOP, 32'h6);
    for (k = 0; k < 4; k++) begin
      wreg(`FBP_REG_CFG, 32'h9 | (32'(al[k]) << 12));
      wreg(`FBP_REG_SHIFT0, 32'(sh[k]));
      base = al[k] == 0 ? 0 : (al[k] == 2 ? 7 : 3);
      for (c = 0; c < 10; c++) e[c] = ((c + 21 - base - sh[k]) % 10) < 3;
      repeat (12) @(posedge clock);
      grab(p);
      chk("edges", 32'(e), 32'(p));
    end
    watch <= 1'b0;
    wreg(`FBP_REG_CFG, 32'h0001C009);
    repeat (12) @(posedge clock);
    per(40);
    chk("inverted high", 32'd28, hc[0]);
    chk("inverted start", 32'd32, sc);
    chk("inverted low", 32'd40, lc[0]);
    @(posedge clock);
    ce <= 1'b0;
    repeat (5) @(posedge clock);
    ce <= 1'b1;
    rreg(`FBP_REG_STATUS, 32'h0, 32'hFFFFF000, "status");
    chk("cross conduction", 32'h0, {24'h0, shoots});
    complete_run;
  end
endmodule // fbp_pwm_tb_top
